// *** pkg/cgp_pkg.sv ***
// Summary of operation
// - while the analog power-down bit is set, the analog processing clock enable is held off until it clears.
// - while the digital power-down bit is set, the digital clock enable is off and no adpcm initialization starts.
// - the sidetone/transmit, receive-path and digital receive gain registers clear while the power-down/reset pin is low.
// - the sidetone field in bits 6 to 4 selects full attenuation for code 0, then -21.5 up to -8.0 dB.
// - the transmit mute bit replaces the converted transmit sample with zero toward the processing engine.
// - the transmit gain field in bits 2 to 0 selects 0 dB up to +6.8 dB.
// - the reference select bit picks a fixed 2.5 V reference when one and half the external supply when zero.
// - the auxiliary output amplifier is enabled only while its enable bit is one.
// - the power output amplifier is disabled while its disable bit is one and runs while it is zero and no power-down is active.
// - during power-down both output amplifier pins go high impedance regardless of their control bits.
// - the receive mute bit grounds the receive amplifier input while the amplifier stays biased.
// - the receive attenuation field sets minus the code in dB, 0 to -7 dB.
// - the digital receive gain routine is applied only while its enable bit is one.
// - the seven-bit gain factor is fixed point with two integer bits above the binary point.
package cgp_pkg;
   localparam int CGP_IDX_W = 4;
   localparam logic [3:0] CGP_IDX_MAIN = 4'h0;
   localparam logic [3:0] CGP_IDX_STXG = 4'h1;
   localparam logic [3:0] CGP_IDX_RXPC = 4'h2;
   localparam logic [3:0] CGP_IDX_DRXG = 4'h3;
   localparam logic [7:0] CGP_RST_VAL = 8'h00;
   localparam logic [7:0] CGP_MAIN_MASK = 8'h03;
   localparam logic [7:0] CGP_STXG_MASK = 8'h7f;
   localparam logic [7:0] CGP_RXPC_MASK = 8'hef;
   localparam logic [7:0] CGP_DRXG_MASK = 8'hff;
   localparam int CGP_APD_BIT = 1;
   localparam int CGP_DPD_BIT = 0;
   localparam int CGP_TXMUTE_BIT = 3;
   localparam int CGP_REFSEL_BIT = 7;
   localparam int CGP_AUXEN_BIT = 6;
   localparam int CGP_PWRDIS_BIT = 5;
   localparam int CGP_RXMUTE_BIT = 3;
   localparam int CGP_DGEN_BIT = 7;
   localparam int CGP_TXW = 14;

   typedef struct packed {
      logic analog_clk_en;
      logic digital_clk_en;
      logic adpcm_init;
      logic [2:0] sidetone_sel;
      logic tx_mute;
      logic [2:0] tx_gain_sel;
      logic ref_fixed_2v5;
      logic aux_amp_en;
      logic aux_amp_oe;
      logic pwr_amp_en;
      logic pwr_amp_oe;
      logic rx_mute_gnd;
      logic rx_amp_bias;
      logic [2:0] rx_atten_db;
      logic dig_gain_en;
      logic [1:0] dig_gain_int;
      logic [4:0] dig_gain_frac;
   } cgp_ctrl_t;

   typedef enum logic [1:0] {
      CGP_RUN = 2'b00,
      CGP_DOWN = 2'b01,
      CGP_WAKE = 2'b11
   } cgp_state_t;
endpackage

// *** hw/cgp_tx_path.sv ***
`timescale 1ns/1ns
module cgp_tx_path
   import cgp_pkg::*;
#(
   parameter int W = CGP_TXW
)
(
   input wire logic clk_in, // clock
   input wire logic rst_in, // async reset
   input wire logic ce_in, // clock enable
   input wire logic run_in, // digital path running
   input wire logic mute_in, // transmit mute
   input wire logic [W-1:0] sample_in, // converted sample
   input wire logic valid_in, // sample strobe
   output logic [W-1:0] sample_out, // sample to engine
   output logic valid_out // output strobe
);
   logic [W-1:0] data_ff, nxt_data;
   logic vld_ff, nxt_vld;

   always_comb
   begin
      nxt_vld = run_in & valid_in;
      nxt_data = data_ff;
      if (run_in & valid_in)
      begin
         nxt_data = mute_in ? '0 : sample_in;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         data_ff <= '0;
         vld_ff <= 1'b0;
      end
      else if (ce_in)
      begin
         data_ff <= nxt_data;
         vld_ff <= nxt_vld;
      end
   end

   assign sample_out = data_ff;
   assign valid_out = vld_ff;
endmodule

// *** hw/cgp_regs.sv ***
`timescale 1ns/1ns
module cgp_regs
   import cgp_pkg::*;
(
   input wire logic clk_in, // 50 mhz clock
   input wire logic rst_in, // async reset, high
   input wire logic ce_in, // clock enable
   input wire logic powerdown_reset_pin_n_in, // low clears and powers down
   input wire logic wr_in, // byte write strobe from setup serial port
   input wire logic rd_in, // byte read strobe from setup serial port
   input wire logic [CGP_IDX_W-1:0] idx_in, // register index
   input wire logic [7:0] wdata_in, // write data
   input wire logic [CGP_TXW-1:0] tx_sample_in, // converter sample
   input wire logic tx_valid_in, // converter strobe
   output logic [7:0] rdata_out, // read data
   output logic rvalid_out, // read data valid
   output cgp_ctrl_t ctrl_out, // decoded controls
   output logic [CGP_TXW-1:0] tx_sample_out, // sample to engine
   output logic tx_valid_out // engine strobe
);
   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   logic [7:0] main_ff, stxg_ff, rxpc_ff, drxg_ff;
   logic [7:0] nxt_main, nxt_stxg, nxt_rxpc, nxt_drxg;
   logic [7:0] rdata_ff, nxt_rdata;
   logic rvalid_ff, nxt_rvalid;

   function automatic logic [7:0] sel_rd(input logic [3:0] i, input logic [7:0] m,
                                         input logic [7:0] s, input logic [7:0] r,
                                         input logic [7:0] d);
      case (i)
         CGP_IDX_MAIN: sel_rd = m & CGP_MAIN_MASK;
         CGP_IDX_STXG: sel_rd = s & CGP_STXG_MASK;
         CGP_IDX_RXPC: sel_rd = r & CGP_RXPC_MASK;
         CGP_IDX_DRXG: sel_rd = d & CGP_DRXG_MASK;
         default: sel_rd = 8'h00;
      endcase
   endfunction

   always_comb
   begin
      nxt_main = main_ff;
      nxt_stxg = stxg_ff;
      nxt_rxpc = rxpc_ff;
      nxt_drxg = drxg_ff;
      nxt_rvalid = rd_in;
      nxt_rdata = rd_in ? sel_rd(idx_in, main_ff, stxg_ff, rxpc_ff, drxg_ff) : rdata_ff;
      if (wr_in)
      begin
         case (idx_in)
            CGP_IDX_MAIN: nxt_main = wdata_in & CGP_MAIN_MASK;
            CGP_IDX_STXG: nxt_stxg = wdata_in & CGP_STXG_MASK;
            CGP_IDX_RXPC: nxt_rxpc = wdata_in & CGP_RXPC_MASK;
            CGP_IDX_DRXG: nxt_drxg = wdata_in;
            default: ;
         endcase
      end
      if (!powerdown_reset_pin_n_in)
      begin
         nxt_main = CGP_RST_VAL;
         nxt_stxg = CGP_RST_VAL;
         nxt_rxpc = CGP_RST_VAL;
         nxt_drxg = CGP_RST_VAL;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         main_ff <= CGP_RST_VAL;
         stxg_ff <= CGP_RST_VAL;
         rxpc_ff <= CGP_RST_VAL;
         drxg_ff <= CGP_RST_VAL;
         rdata_ff <= CGP_RST_VAL;
         rvalid_ff <= 1'b0;
      end
      else if (ce_in)
      begin
         main_ff <= nxt_main;
         stxg_ff <= nxt_stxg;
         rxpc_ff <= nxt_rxpc;
         drxg_ff <= nxt_drxg;
         rdata_ff <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
      end
   end

   assign rdata_out = rdata_ff;
   assign rvalid_out = rvalid_ff;

   // ---------------------------------------------------------------
   // digital power state
   // ---------------------------------------------------------------
   cgp_state_t st_ff, nxt_st;
   logic dig_down, ana_down, any_down;
   logic init_ff, nxt_init;

   always_comb
   begin
      dig_down = main_ff[CGP_DPD_BIT] | ~powerdown_reset_pin_n_in;
      ana_down = main_ff[CGP_APD_BIT] | ~powerdown_reset_pin_n_in;
      any_down = dig_down | ana_down;
      nxt_st = st_ff;
      nxt_init = 1'b0;
      case (st_ff)
         CGP_RUN: if (dig_down) nxt_st = CGP_DOWN;
         CGP_DOWN: if (!dig_down) nxt_st = CGP_WAKE;
         CGP_WAKE:
         begin
            nxt_init = 1'b1; // adpcm restarts from initial state
            nxt_st = dig_down ? CGP_DOWN : CGP_RUN;
         end
         default: nxt_st = CGP_RUN;
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         st_ff <= CGP_RUN;
         init_ff <= 1'b0;
      end
      else if (ce_in)
      begin
         st_ff <= nxt_st;
         init_ff <= nxt_init;
      end
   end

   // ---------------------------------------------------------------
   // decoded controls
   // ---------------------------------------------------------------
   cgp_ctrl_t ctrl_ff, nxt_ctrl;

   always_comb
   begin
      nxt_ctrl.analog_clk_en = ~ana_down;
      nxt_ctrl.digital_clk_en = ~dig_down;
      nxt_ctrl.adpcm_init = init_ff & ~dig_down;
      nxt_ctrl.sidetone_sel = stxg_ff[6:4];
      nxt_ctrl.tx_mute = stxg_ff[CGP_TXMUTE_BIT];
      nxt_ctrl.tx_gain_sel = stxg_ff[2:0];
      nxt_ctrl.ref_fixed_2v5 = rxpc_ff[CGP_REFSEL_BIT];
      nxt_ctrl.aux_amp_en = rxpc_ff[CGP_AUXEN_BIT] & ~any_down;
      nxt_ctrl.aux_amp_oe = ~any_down;
      nxt_ctrl.pwr_amp_en = ~rxpc_ff[CGP_PWRDIS_BIT] & ~any_down;
      nxt_ctrl.pwr_amp_oe = ~any_down;
      nxt_ctrl.rx_mute_gnd = rxpc_ff[CGP_RXMUTE_BIT];
      nxt_ctrl.rx_amp_bias = ~any_down;
      nxt_ctrl.rx_atten_db = rxpc_ff[2:0];
      nxt_ctrl.dig_gain_en = drxg_ff[CGP_DGEN_BIT];
      nxt_ctrl.dig_gain_int = drxg_ff[6:5];
      nxt_ctrl.dig_gain_frac = drxg_ff[4:0];
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ctrl_ff <= '0;
      end
      else if (ce_in)
      begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   assign ctrl_out = ctrl_ff;

   cgp_tx_path #(.W(CGP_TXW)) u_tx (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .run_in(~dig_down),
      .mute_in(stxg_ff[CGP_TXMUTE_BIT]),
      .sample_in(tx_sample_in),
      .valid_in(tx_valid_in),
      .sample_out(tx_sample_out),
      .valid_out(tx_valid_out)
   );
endmodule

// *** dv/cgp_monitor.sv ***
`timescale 1ns/1ns
module cgp_monitor
   import cgp_pkg::*;
(
   input wire logic clk_in, // clock
   input wire logic rst_in, // reset
   input wire logic ce_in, // enable
   input wire logic powerdown_reset_pin_n_in, // pin
   input wire logic wr_in, // write
   input wire logic rd_in, // read
   input wire logic [CGP_IDX_W-1:0] idx_in, // index
   input wire logic [7:0] wdata_in, // data
   input wire logic [7:0] rdata_out, // read data
   input wire logic rvalid_out, // read valid
   input wire cgp_ctrl_t ctrl_out, // controls
   input wire logic [CGP_TXW-1:0] tx_sample_out, // sample
   input wire logic tx_valid_out // strobe
);
   logic [3:0] wi;
   logic [7:0] w_d1;
   logic [7:0] w_d2;
   // -------------------------------
   // write index seen, data history
   // -------------------------------
   assign wi = (wr_in && ce_in && powerdown_reset_pin_n_in) ? idx_in : 4'hf;
   always_ff @(posedge clk_in)
   begin
      w_d1 <= wdata_in;
      w_d2 <= w_d1;
   end
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   a_read_answer: assert property (rd_in && ce_in |=> rvalid_out)
      else $error("read not answered");
   a_bad_index: assert property (rd_in && ce_in && idx_in > CGP_IDX_DRXG |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_rsvd_zero: assert property (rd_in && ce_in && idx_in == CGP_IDX_RXPC |=> !rdata_out[4])
      else $error("reserved bit read one");
   a_tx_fields: assert property (wi == CGP_IDX_STXG ##1 ce_in ##1 1'b1 |->
      {ctrl_out.sidetone_sel, ctrl_out.tx_mute, ctrl_out.tx_gain_sel} == w_d2[6:0]) else $error("tx fields");
   a_rx_fields: assert property (wi == CGP_IDX_RXPC ##1 ce_in ##1 1'b1 |-> ctrl_out.ref_fixed_2v5 == w_d2[7]
      && ctrl_out.rx_mute_gnd == w_d2[3] && ctrl_out.rx_atten_db == w_d2[2:0]) else $error("rx fields");
   a_gain_fields: assert property (wi == CGP_IDX_DRXG ##1 ce_in ##1 1'b1 |->
      {ctrl_out.dig_gain_en, ctrl_out.dig_gain_int, ctrl_out.dig_gain_frac} == w_d2) else $error("gain fields");
   a_main_clocks: assert property (wi == CGP_IDX_MAIN ##1 ce_in && powerdown_reset_pin_n_in ##1 1'b1 |->
      ctrl_out.analog_clk_en == !w_d2[1] && ctrl_out.digital_clk_en == !w_d2[0]) else $error("clock enables");
   a_pin_clear: assert property (!powerdown_reset_pin_n_in && ce_in ##1 ce_in |=> ctrl_out.sidetone_sel == 3'h0
      && !ctrl_out.tx_mute && !ctrl_out.dig_gain_en && ctrl_out.rx_atten_db == 3'h0) else $error("pin clear");
   a_amp_float: assert property (!ctrl_out.aux_amp_oe |-> !ctrl_out.pwr_amp_oe && !ctrl_out.aux_amp_en)
      else $error("amp driven in power-down");
   a_init_held: assert property (!ctrl_out.digital_clk_en |-> !ctrl_out.adpcm_init)
      else $error("init while down");
   a_tx_muted: assert property (ctrl_out.tx_mute && $past(ctrl_out.tx_mute) && tx_valid_out |-> tx_sample_out == '0)
      else $error("muted sample not zero");
endmodule
bind cgp_regs cgp_monitor u_mon (.*);

// *** dv/cgp_host_model.sv ***
`timescale 1ns/1ns
module cgp_host_model
   import cgp_pkg::*;
(
   input wire logic clk_in, // clock
   output logic wr_out = 1'b0, // write strobe
   output logic rd_out = 1'b0, // read strobe
   output logic [CGP_IDX_W-1:0] idx_out = '0, // register index
   output logic [7:0] wdata_out = '0 // write data
);
   // -------------------------------
   // one byte transfer, then idle
   // -------------------------------
   task automatic xfer(input logic w, input logic [3:0] i, input logic [7:0] d);
      @(negedge clk_in);
      wr_out = w;
      rd_out = !w;
      idx_out = i;
      wdata_out = d;
      @(negedge clk_in);
      wr_out = 1'b0;
      rd_out = 1'b0;
      idx_out = ~i;
      wdata_out = ~d;
   endtask
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ns
module tb_top
   import cgp_pkg::*;
   ;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic pin_n = 1'b1;
   logic ce = 1'b1;
   logic txv = 1'b0;
   logic wr, rd, rvalid, txvo;
   logic [3:0] idx;
   logic [7:0] wd, rdata;
   logic [CGP_TXW-1:0] txs = '0;
   logic [CGP_TXW-1:0] txso;
   cgp_ctrl_t ctrl;
   int fails = 0;
   int compares = 0;
   int cyc = 0;
   localparam logic [19:0] ROWS [7] = '{20'h1ff7f, 20'h2ffef, 20'h3ffff, 20'h0ff03, 20'hfff00, 20'h25a4a, 20'h00000};
   cgp_regs DUT (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .powerdown_reset_pin_n_in(pin_n), .wr_in(wr),
      .rd_in(rd), .idx_in(idx), .wdata_in(wd), .tx_sample_in(txs), .tx_valid_in(txv), .rdata_out(rdata),
      .rvalid_out(rvalid), .ctrl_out(ctrl), .tx_sample_out(txso), .tx_valid_out(txvo));
   cgp_host_model u_host (.clk_in(clk_in), .wr_out(wr), .rd_out(rd), .idx_out(idx), .wdata_out(wd));
   // -------------------------------
   // clock, timeout, checks
   // -------------------------------
   initial
   begin
      forever #10 clk_in = ~clk_in;
   end
   task automatic print_verdict();
      if (fails == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge clk_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         fails = fails + 1;
         print_verdict();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares = compares + 1;
      if (got !== exp)
      begin
         fails = fails + 1;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   initial
   begin
      int n;
      repeat (8) @(posedge clk_in);
      @(negedge clk_in);
      rst_in = 1'b0;
      for (int i = 1; i < 4; i++)
      begin
         u_host.xfer(1'b0, i[3:0], 8'h00);
         chk(rdata, 8'h00);
      end
      chk({6'h0, ctrl.aux_amp_en, ctrl.pwr_amp_en}, 8'h01);
      foreach (ROWS[r])
      begin
         u_host.xfer(1'b1, ROWS[r][19:16], ROWS[r][15:8]);
         u_host.xfer(1'b0, ROWS[r][19:16], 8'h00);
         chk({7'h0, rvalid}, 8'h01);
         chk(rdata, ROWS[r][7:0]);
      end
      for (int k = 0; k < 8; k++)
      begin
         u_host.xfer(1'b1, CGP_IDX_STXG, {1'b0, k[2:0], 1'b0, k[2:0]});
         u_host.xfer(1'b1, CGP_IDX_RXPC, {5'h00, k[2:0]});
         @(negedge clk_in);
         chk({2'h0, ctrl.sidetone_sel, ctrl.tx_gain_sel}, {2'h0, k[2:0], k[2:0]});
         chk({5'h0, ctrl.rx_atten_db}, {5'h0, k[2:0]});
      end
      u_host.xfer(1'b1, CGP_IDX_RXPC, 8'hc8);
      @(negedge clk_in);
      chk({3'h0, ctrl.ref_fixed_2v5, ctrl.aux_amp_en, ctrl.rx_mute_gnd, ctrl.rx_amp_bias, ctrl.pwr_amp_en}, 8'h1f);
      u_host.xfer(1'b1, CGP_IDX_MAIN, 8'h02);
      @(negedge clk_in);
      chk({5'h0, ctrl.analog_clk_en, ctrl.digital_clk_en, ctrl.aux_amp_oe}, 8'h02);
      u_host.xfer(1'b1, CGP_IDX_MAIN, 8'h01);
      @(negedge clk_in);
      chk({6'h0, ctrl.analog_clk_en, ctrl.digital_clk_en}, 8'h02);
      u_host.xfer(1'b1, CGP_IDX_MAIN, 8'h00);
      n = 0;
      while (ctrl.adpcm_init !== 1'b1 && n < 8)
      begin
         @(negedge clk_in);
         n++;
      end
      chk({7'h0, ctrl.adpcm_init}, 8'h01);
      for (int m = 0; m < 2; m++)
      begin
         u_host.xfer(1'b1, CGP_IDX_STXG, m ? 8'h00 : 8'h08);
         @(negedge clk_in);
         txs = 14'h1abc;
         txv = 1'b1;
         @(negedge clk_in);
         txv = 1'b0;
         txs = 14'h2543;
         chk({7'h0, txvo}, 8'h01);
         chk(txso[7:0], m ? 8'hbc : 8'h00);
      end
      // clock enable low: write must not land
      ce = 1'b0;
      u_host.xfer(1'b1, CGP_IDX_STXG, 8'h7f);
      ce = 1'b1;
      @(negedge clk_in);
      @(negedge clk_in);
      chk({1'b0, ctrl.sidetone_sel, ctrl.tx_mute, ctrl.tx_gain_sel}, 8'h00);
      u_host.xfer(1'b1, CGP_IDX_DRXG, 8'hff);
      pin_n = 1'b0;
      @(negedge clk_in);
      chk({ctrl.dig_gain_en, ctrl.dig_gain_int, ctrl.dig_gain_frac}, 8'hff);
      @(negedge clk_in);
      chk({7'h0, ctrl.aux_amp_oe}, 8'h00);
      pin_n = 1'b1;
      u_host.xfer(1'b0, CGP_IDX_DRXG, 8'h00);
      chk(rdata, 8'h00);
      print_verdict();
   end
endmodule
